/* retirement_trace_port.sv */
// Functional notes
// - outputs meaningful only while valid high
// - valid per retire, order plus one
// - other outputs arbitrary while valid low
// - fourteen-bit trap record field layout
// - trap flag on exception or debug entry
// - exception flag non-debug, debug flag debug
// - stepped exception sets both flags
// - side effects and jump next cycle
// - load fault cause 0x05, subtype source
// - store/atomic fault cause 0x07, subtype source
// - illegal 0x02, breakpoint 0x03, subtype zero
// - machine ecall cause 0x0B
// - fetch bus error cause 0x30
// - non-executable fetch cause 0x01
// - halt reasons breakpoint, trigger, step
// - handler-entry record on first handler instruction
// - exception entry record clear for debug traps, interrupt entry kept
// - interrupts fall between instructions
// - next pc ignores async events
// - misaligned address is first sub-transfer
// - counter csrs as one vectorized port
// - counter changes shown as side effects
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "retirement_trace_port_cfg.svh"

module retirement_trace_port
    import retirement_trace_port_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pipeline retirement side
    input wire logic ret_valid,
    input wire logic [31:0] ret_pc,
    input wire logic [31:0] ret_next_pc,
    input wire logic [31:0] ret_mem_addr,
    input wire trap_kind_t ret_kind,
    input wire logic ret_trigger,
    input wire logic ret_step,
    input wire logic ebreak_to_debug,
    input wire logic in_debug,
    input wire logic irq_taken,
    input wire logic [10:0] irq_cause,
    // trace outputs
    output logic tr_valid,
    output logic [63:0] tr_order,
    output logic [13:0] tr_trap,
    output logic [13:0] tr_intr,
    output logic [31:0] tr_pc_rdata,
    output logic [31:0] tr_pc_wdata,
    output logic [31:0] tr_mem_addr,
    output logic [1:0][31:0] tr_csr_cnt_rmask,
    output logic [1:0][31:0] tr_csr_cnt_wmask,
    output logic [1:0][31:0] tr_csr_cnt_rdata,
    output logic [1:0][31:0] tr_csr_cnt_wdata,
    output logic tr_halt,
    // handler redirect strobe
    output logic trap_redirect
);

    // build one trap record from the pipeline's fault source
    function automatic logic [13:0] build_trap(
        input trap_kind_t kind,
        input logic trig,
        input logic step,
        input logic brk_dbg,
        input logic dbg_mode
    );
        logic [5:0] cause;
        logic [2:0] dcause;
        logic [1:0] sub;
        logic exc;
        logic dbg;
        logic [13:0] rec;
        cause = 6'h00;
        dcause = 3'h0;
        sub = `RTP_SUB_MISAL;
        exc = 1'b0;
        dbg = 1'b0;
        rec = 14'h0000;
        if (trig)
        begin
            // timing-zero trigger fires before the instruction executes
            dbg = 1'b1;
            dcause = `RTP_DBG_TRIG;
        end
        else
        begin
            exc = 1'b1;
            case (kind)
                TK_IAF: cause = `RTP_EXC_IAF;
                TK_ILL: cause = `RTP_EXC_ILL;
                TK_BRK:
                begin
                    if (brk_dbg || dbg_mode)
                    begin
                        // breakpoint into debug, no exception
                        exc = 1'b0;
                        dbg = 1'b1;
                        dcause = `RTP_DBG_BRK;
                    end
                    else
                    begin
                        cause = `RTP_EXC_BRK;
                    end
                end
                TK_LD_IO: cause = `RTP_EXC_LAF;
                TK_LD_RSV:
                begin
                    cause = `RTP_EXC_LAF;
                    sub = `RTP_SUB_ATOMIC;
                end
                TK_ST_IO: cause = `RTP_EXC_SAF;
                TK_ST_AMO:
                begin
                    cause = `RTP_EXC_SAF;
                    sub = `RTP_SUB_ATOMIC;
                end
                TK_ECALL: cause = `RTP_EXC_ECALL;
                TK_IBUS: cause = `RTP_EXC_IBUS;
                default: exc = 1'b0;
            endcase
        end
        if (step && !dbg)
        begin
            // step keeps any exception flag alongside debug
            dbg = 1'b1;
            dcause = `RTP_DBG_STEP;
        end
        rec[`RTP_TRAP_BIT] = exc | dbg;
        rec[`RTP_TRAP_EXC_BIT] = exc;
        rec[`RTP_TRAP_DBG_BIT] = dbg;
        rec[`RTP_TRAP_CAUSE_LSB +: 6] = cause;
        rec[`RTP_TRAP_DCAUSE_LSB +: 3] = dcause;
        rec[`RTP_TRAP_SUB_LSB +: 2] = sub;
        return rec;
    endfunction

    // register state
    logic [1:0] ctrl; // enable and halt
    logic [31:0] cycle_cnt; // free-running cycle counter
    logic [31:0] instret_cnt; // retired instruction counter
    entry_state_t entry_state; // owed handler entry
    logic [10:0] entry_cause; // cause for owed entry

    // combinational helpers
    logic emit; // a record is loaded this cycle and goes out the next
    logic [13:0] next_trap; // record for the current instruction
    logic is_dbg_trap; // current record enters debug
    logic is_exc_trap; // current record takes an exception and does not enter debug
    logic apb_setup; // setup phase of an apb transfer
    logic apb_wr; // completing write
    logic [31:0] next_rdata; // read mux
    logic next_err; // unmapped address
    logic [31:0] next_cycle; // cycle counter after this cycle
    logic [31:0] next_instret; // instret after this instruction

    assign emit = ret_valid && ctrl[`RTP_CTRL_EN_BIT];
    assign next_trap = build_trap(ret_kind, ret_trigger, ret_step, ebreak_to_debug, in_debug);
    assign is_dbg_trap = next_trap[`RTP_TRAP_DBG_BIT];
    assign is_exc_trap = next_trap[`RTP_TRAP_EXC_BIT] && !is_dbg_trap;
    assign apb_setup = psel && !penable && !pready;
    assign apb_wr = psel && penable && pready && pwrite;
    assign next_cycle = cycle_cnt + 32'h0000_0001;
    // trapped instructions do not retire, so they do not count
    assign next_instret = instret_cnt + {31'h0000_0000, !next_trap[`RTP_TRAP_BIT]};

    // apb read mux and decode of unmapped offsets
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            `RTP_CTRL_OFS: next_rdata = {30'h0000_0000, ctrl};
            `RTP_ORDER_LO_OFS: next_rdata = tr_order[31:0];
            `RTP_ORDER_HI_OFS: next_rdata = tr_order[63:32];
            `RTP_CYCLE_OFS: next_rdata = cycle_cnt;
            `RTP_INSTRET_OFS: next_rdata = instret_cnt;
            default: next_err = 1'b1;
        endcase
    end

    // apb handshake: ready registered one cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready <= apb_setup;
            if (apb_setup)
            begin
                // reads of registers are side-effect free
                prdata <= next_rdata;
                pslverr <= next_err;
            end
        end
    end

    // control register; writes to read-only offsets are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `RTP_CTRL_RST;
        end
        else if (ce && apb_wr && paddr == `RTP_CTRL_OFS)
        begin
            ctrl <= pwdata[1:0];
        end
    end

    // halt output: a compliant core never locks up, software may force it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tr_halt <= 1'b0;
        end
        else if (ce)
        begin
            tr_halt <= ctrl[`RTP_CTRL_HALT_BIT];
        end
    end

    // cycle counter advances every enabled clock, instret as a side effect of instructions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cycle_cnt <= 32'h0000_0000;
            instret_cnt <= 32'h0000_0000;
        end
        else if (ce)
        begin
            cycle_cnt <= next_cycle;
            if (ret_valid)
            begin
                instret_cnt <= next_instret;
            end
        end
    end

    // valid strobe and order counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tr_valid <= 1'b0;
            tr_order <= 64'h0000_0000_0000_0000;
        end
        else if (ce)
        begin
            tr_valid <= emit;
            if (emit)
            begin
                tr_order <= tr_order + 64'h0000_0000_0000_0001;
            end
        end
    end

    // record payload; only loaded on emit, stale otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tr_trap <= 14'h0000;
            tr_pc_rdata <= 32'h0000_0000;
            tr_pc_wdata <= 32'h0000_0000;
            tr_mem_addr <= 32'h0000_0000;
        end
        else if (ce && emit)
        begin
            tr_trap <= next_trap;
            tr_pc_rdata <= ret_pc;
            // prediction from the pipeline, async events not folded in
            tr_pc_wdata <= ret_next_pc;
            // pipeline already hands over the first sub-transfer address
            tr_mem_addr <= ret_mem_addr;
        end
    end

    // counter csr slots: 0 cycle, 1 instret
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cnt
            logic [31:0] cur; // value before the instruction
            logic [31:0] nxt; // value after the instruction
            assign cur = (gi == 0) ? cycle_cnt : instret_cnt;
            assign nxt = (gi == 0) ? next_cycle : next_instret;
            // counter slot loaded with the record
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    tr_csr_cnt_rmask[gi] <= 32'h0000_0000;
                    tr_csr_cnt_wmask[gi] <= 32'h0000_0000;
                    tr_csr_cnt_rdata[gi] <= 32'h0000_0000;
                    tr_csr_cnt_wdata[gi] <= 32'h0000_0000;
                end
                else if (ce && emit)
                begin
                    tr_csr_cnt_rmask[gi] <= 32'hffff_ffff;
                    tr_csr_cnt_wmask[gi] <= 32'hffff_ffff;
                    tr_csr_cnt_rdata[gi] <= cur;
                    tr_csr_cnt_wdata[gi] <= nxt;
                end
            end
        end
    endgenerate

    // handler-entry bookkeeping; a new cause wins over consumption
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            entry_state <= ENTRY_IDLE;
            entry_cause <= 11'h000;
        end
        else if (ce)
        begin
            if (ret_valid && is_exc_trap)
            begin
                entry_state <= ENTRY_EXC;
                entry_cause <= {5'h00, next_trap[`RTP_TRAP_CAUSE_LSB +: 6]};
            end
            else if (irq_taken)
            begin
                // taken between instructions, nothing on the one before
                entry_state <= ENTRY_IRQ;
                entry_cause <= irq_cause;
            end
            else if (ret_valid)
            begin
                entry_state <= ENTRY_IDLE;
            end
        end
    end

    // entry record for the first handler instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tr_intr <= 14'h0000;
        end
        else if (ce && emit)
        begin
            tr_intr <= 14'h0000;
            // debug traps hide an exception entry, not an interrupt one
            case (entry_state)
                ENTRY_EXC:
                begin
                    if (!is_dbg_trap)
                    begin
                        tr_intr[`RTP_ENTRY_BIT] <= 1'b1;
                        tr_intr[`RTP_ENTRY_EXC_BIT] <= 1'b1;
                        tr_intr[`RTP_ENTRY_CAUSE_LSB +: 11] <= entry_cause;
                    end
                end
                ENTRY_IRQ:
                begin
                    tr_intr[`RTP_ENTRY_BIT] <= 1'b1;
                    tr_intr[`RTP_ENTRY_IRQ_BIT] <= 1'b1;
                    tr_intr[`RTP_ENTRY_CAUSE_LSB +: 11] <= entry_cause;
                end
                default: tr_intr <= 14'h0000;
            endcase
        end
    end

    // redirect one cycle after a trapping record goes out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trap_redirect <= 1'b0;
        end
        else if (ce)
        begin
            trap_redirect <= tr_valid && tr_trap[`RTP_TRAP_BIT];
        end
    end

    // checks
    chk_order_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && emit |=> tr_valid && tr_order == $past(tr_order) + 64'h0000_0000_0000_0001)
        else $error("order did not advance by one");
    chk_order_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !emit |=> !tr_valid && $stable(tr_order))
        else $error("order moved without a record");
    chk_trap_flag: assert property (@(posedge pclk) disable iff (!presetn)
        tr_valid |-> tr_trap[0] == (tr_trap[1] | tr_trap[2]))
        else $error("trap flag not exception or debug");
    chk_step_both: assert property (@(posedge pclk) disable iff (!presetn)
        ce && emit && ret_step && !ret_trigger && ret_kind == TK_ILL
        |=> tr_trap[2:0] == 3'h7 && tr_trap[11:9] == 3'h4)
        else $error("stepped exception lost a flag");
    chk_redirect: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tr_valid && tr_trap[0] |=> trap_redirect)
        else $error("no redirect after trap record");
    chk_load_rsv: assert property (@(posedge pclk) disable iff (!presetn)
        ce && emit && ret_kind == TK_LD_RSV && !ret_trigger && !ret_step
        |=> tr_trap[8:3] == 6'h05 && tr_trap[13:12] == 2'h1)
        else $error("load reserved fault misreported");
    chk_ecall: assert property (@(posedge pclk) disable iff (!presetn)
        ce && emit && ret_kind == TK_ECALL && !ret_trigger && !ret_step
        |=> tr_trap[8:3] == 6'h0b && tr_trap[13:12] == 2'h0)
        else $error("ecall cause wrong");
    chk_irq_entry: assert property (@(posedge pclk) disable iff (!presetn)
        ce && irq_taken && !(ret_valid && is_exc_trap) ##1 ce && emit && !irq_taken
        |=> tr_intr[2:0] == 3'h5)
        else $error("interrupt entry not flagged");
    chk_cnt_effect: assert property (@(posedge pclk) disable iff (!presetn)
        tr_valid |-> tr_csr_cnt_wdata[0] == tr_csr_cnt_rdata[0] + 32'h0000_0001)
        else $error("cycle side effect wrong");

endmodule // retirement_trace_port

/* retirement_trace_port_cfg.svh */
`ifndef RETIREMENT_TRACE_PORT_CFG_SVH
`define RETIREMENT_TRACE_PORT_CFG_SVH

// register byte offsets
`define RTP_CTRL_OFS 12'h000
`define RTP_ORDER_LO_OFS 12'h004
`define RTP_ORDER_HI_OFS 12'h008
`define RTP_CYCLE_OFS 12'h00c
`define RTP_INSTRET_OFS 12'h010

// control fields and reset value
`define RTP_CTRL_EN_BIT 0
`define RTP_CTRL_HALT_BIT 1
`define RTP_CTRL_RST 2'h1

// trap record field positions
`define RTP_TRAP_BIT 0
`define RTP_TRAP_EXC_BIT 1
`define RTP_TRAP_DBG_BIT 2
`define RTP_TRAP_CAUSE_LSB 3
`define RTP_TRAP_DCAUSE_LSB 9
`define RTP_TRAP_SUB_LSB 12

// handler-entry record field positions
`define RTP_ENTRY_BIT 0
`define RTP_ENTRY_EXC_BIT 1
`define RTP_ENTRY_IRQ_BIT 2
`define RTP_ENTRY_CAUSE_LSB 3

// exception causes
`define RTP_EXC_IAF 6'h01
`define RTP_EXC_ILL 6'h02
`define RTP_EXC_BRK 6'h03
`define RTP_EXC_LAF 6'h05
`define RTP_EXC_SAF 6'h07
`define RTP_EXC_ECALL 6'h0b
`define RTP_EXC_IBUS 6'h30

// halt reason codes and fault subtypes
`define RTP_DBG_BRK 3'h1
`define RTP_DBG_TRIG 3'h2
`define RTP_DBG_STEP 3'h4
`define RTP_SUB_MISAL 2'h0
`define RTP_SUB_ATOMIC 2'h1

`endif

/* retirement_trace_port_pkg.sv */
package retirement_trace_port_pkg;

    // synchronous fault source reported by the pipeline
    typedef enum logic [3:0]
    {
        TK_NONE = 4'b0000,
        TK_IAF = 4'b0001,
        TK_ILL = 4'b0010,
        TK_BRK = 4'b0011,
        TK_LD_IO = 4'b0100,
        TK_LD_RSV = 4'b0101,
        TK_ST_IO = 4'b0110,
        TK_ST_AMO = 4'b0111,
        TK_ECALL = 4'b1000,
        TK_IBUS = 4'b1001
    } trap_kind_t;

    // what the next reported instruction owes as handler entry
    typedef enum logic [1:0]
    {
        ENTRY_IDLE = 2'b00,
        ENTRY_EXC = 2'b01,
        ENTRY_IRQ = 2'b10
    } entry_state_t;

endpackage

/* tb_top.sv */
`timescale 1ns/100ps
`include "retirement_trace_port_cfg.svh"

module tb_top
    import retirement_trace_port_pkg::*;
;
    // stimulus side
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic ret_valid = 1'b0, ret_trigger = 1'b0, ret_step = 1'b0;
    logic ebreak_to_debug = 1'b0, in_debug = 1'b0, irq_taken = 1'b0;
    logic [31:0] ret_pc = 32'h0000_0000, ret_next_pc = 32'h0000_0000;
    logic [31:0] ret_mem_addr = 32'h0000_0000;
    logic [10:0] irq_cause = 11'h000;
    trap_kind_t ret_kind = TK_NONE;
    // observed side
    logic [31:0] prdata, tr_pc_rdata, tr_pc_wdata, tr_mem_addr, seen;
    logic pready, pslverr, tr_valid, tr_halt, trap_redirect, order_err;
    logic [63:0] tr_order;
    logic [13:0] tr_trap, tr_intr;
    logic [1:0][31:0] tr_csr_cnt_rmask, tr_csr_cnt_wmask, tr_csr_cnt_rdata, tr_csr_cnt_wdata;
    // bench bookkeeping
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0000_51d6;
    logic [63:0] order_exp = 64'h0;
    logic [31:0] instret_exp = 32'h0;
    logic [1:0] pend = 2'd0; // 0 none, 1 exception, 2 interrupt, 3 not predicted
    logic [10:0] pend_cause = 11'h000;
    logic [31:0] rd;
    logic er;

    // 4 ns clock
    always #2 pclk = ~pclk;

    retirement_trace_port retirement_trace_port_inst (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ret_valid(ret_valid), .ret_pc(ret_pc), .ret_next_pc(ret_next_pc),
        .ret_mem_addr(ret_mem_addr), .ret_kind(ret_kind), .ret_trigger(ret_trigger),
        .ret_step(ret_step), .ebreak_to_debug(ebreak_to_debug), .in_debug(in_debug),
        .irq_taken(irq_taken), .irq_cause(irq_cause), .tr_valid(tr_valid),
        .tr_order(tr_order), .tr_trap(tr_trap), .tr_intr(tr_intr),
        .tr_pc_rdata(tr_pc_rdata), .tr_pc_wdata(tr_pc_wdata), .tr_mem_addr(tr_mem_addr),
        .tr_csr_cnt_rmask(tr_csr_cnt_rmask), .tr_csr_cnt_wmask(tr_csr_cnt_wmask),
        .tr_csr_cnt_rdata(tr_csr_cnt_rdata), .tr_csr_cnt_wdata(tr_csr_cnt_wdata),
        .tr_halt(tr_halt), .trap_redirect(trap_redirect));

    trace_observer trace_observer_inst (.pclk(pclk), .presetn(presetn), .tr_valid(tr_valid),
        .tr_order(tr_order), .seen(seen), .order_err(order_err));

    // repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // subtype and cause of each fault source
    function automatic logic [7:0] cause_of(input trap_kind_t k);
        case (k)
            TK_IAF: return {`RTP_SUB_MISAL, `RTP_EXC_IAF};
            TK_ILL: return {`RTP_SUB_MISAL, `RTP_EXC_ILL};
            TK_BRK: return {`RTP_SUB_MISAL, `RTP_EXC_BRK};
            TK_LD_IO: return {`RTP_SUB_MISAL, `RTP_EXC_LAF};
            TK_LD_RSV: return {`RTP_SUB_ATOMIC, `RTP_EXC_LAF};
            TK_ST_IO: return {`RTP_SUB_MISAL, `RTP_EXC_SAF};
            TK_ST_AMO: return {`RTP_SUB_ATOMIC, `RTP_EXC_SAF};
            TK_ECALL: return {`RTP_SUB_MISAL, `RTP_EXC_ECALL};
            TK_IBUS: return {`RTP_SUB_MISAL, `RTP_EXC_IBUS};
            default: return 8'h00;
        endcase
    endfunction

    // expected record, low 14 bits; care mask in bits 29:16
    function automatic logic [29:0] exp_trap(input trap_kind_t k, input logic tg, input logic st,
        input logic bd, input logic dm);
        logic ex;
        logic dbg;
        logic [2:0] dc;
        logic [13:0] m;
        logic [7:0] c;
        c = cause_of(k);
        ex = (k != TK_NONE);
        dbg = 1'b0;
        dc = 3'h0;
        if (tg)
        begin
            ex = 1'b0;
            dbg = 1'b1;
            dc = `RTP_DBG_TRIG;
        end
        else if (k == TK_BRK && (bd || dm))
        begin
            ex = 1'b0;
            dbg = 1'b1;
            dc = `RTP_DBG_BRK;
        end
        // stepping keeps any exception flag beside the debug flag
        if (st && !dbg)
        begin
            dbg = 1'b1;
            dc = `RTP_DBG_STEP;
        end
        m = 14'h0007;
        m[8:3] = {6{ex}};
        m[13:12] = {2{ex && !dbg}};
        m[11:9] = {3{dbg}};
        return {m, 2'h0, c[7:6], dc, c[5:0], dbg, ex, ex | dbg};
    endfunction

    // compare and count
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // apb master: setup, access until pready, release at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one retiring instruction, then its record and the redirect
    task automatic rec(input trap_kind_t k, input logic tg, input logic st, input logic bd,
        input logic dm, input logic en);
        logic [29:0] e;
        logic [31:0] pc;
        logic [31:0] np;
        logic [31:0] ma;
        pc = rnd();
        np = rnd();
        ma = rnd(); // any byte alignment
        e = exp_trap(k, tg, st, bd, dm);
        @(posedge pclk);
        ret_valid <= 1'b1;
        irq_taken <= 1'b0;
        ret_kind <= k;
        ret_trigger <= tg;
        ret_step <= st;
        ebreak_to_debug <= bd;
        in_debug <= dm;
        ret_pc <= pc;
        ret_next_pc <= np;
        ret_mem_addr <= ma;
        @(posedge pclk);
        ret_valid <= 1'b0;
        instret_exp = instret_exp + {31'h0, ~e[0]};
        #1;
        if (!en)
        begin
            chk("valid while disabled", 64'h0, tr_valid);
            pend = 2'd3;
        end
        else
        begin
            order_exp++;
            chk("valid", 64'h1, tr_valid);
            chk("order", order_exp, tr_order);
            chk("trap record", e[13:0] & e[29:16], tr_trap & e[29:16]);
            chk("pc", pc, tr_pc_rdata);
            chk("next pc", np, tr_pc_wdata);
            chk("mem addr", ma, tr_mem_addr);
            chk("cnt rmask", {64{1'b1}}, tr_csr_cnt_rmask);
            chk("cnt wmask", {64{1'b1}}, tr_csr_cnt_wmask);
            chk("cycle wdata", tr_csr_cnt_rdata[0] + 32'h1, tr_csr_cnt_wdata[0]);
            chk("instret wdata", {32'h0, instret_exp}, tr_csr_cnt_wdata[1]);
            if (pend == 2'd1 && !e[2])
            begin
                chk("exc entry", {pend_cause, 3'b011}, tr_intr);
            end
            if (pend == 2'd2)
            begin
                chk("irq entry", {pend_cause, 3'b101}, tr_intr);
            end
            if (pend == 2'd0)
            begin
                chk("no entry", 64'h0, tr_intr);
            end
            pend = (e[1] && !e[2]) ? 2'd1 : (e[1] ? 2'd3 : 2'd0);
            pend_cause = {5'h00, e[8:3]};
            @(posedge pclk);
            #1;
            chk("redirect", e[0], trap_redirect);
        end
    endtask

    // interrupt taken right before the next instruction, which drops it
    task automatic irq(input logic [10:0] c);
        @(posedge pclk);
        irq_taken <= 1'b1;
        irq_cause <= c;
        pend = 2'd2;
        pend_cause = c;
    endtask

    // verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog, well beyond the few hundred cycles the run needs
    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        logic [31:0] r;
        trap_kind_t k;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            rec(trap_kind_t'(i[3:0]), 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        end
        $display("test fault sources done");
        rec(TK_BRK, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        rec(TK_BRK, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        rec(TK_NONE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        rec(TK_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        rec(TK_ILL, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        irq(11'h00b);
        rec(TK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        irq(11'h007);
        rec(TK_NONE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test debug and entry done");
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            k = trap_kind_t'(4'(r[3:0] % 10));
            if (r[20:18] == 3'h0)
            begin
                irq(r[31:21]);
            end
            rec(k, r[7:4] == 4'h0, r[11:8] == 4'h1, r[12], (k == TK_BRK) & r[13], 1'b1);
        end
        $display("test random records done");
        // back-to-back retirements, one record each
        @(posedge pclk);
        ret_valid <= 1'b1;
        ret_kind <= TK_NONE;
        ret_trigger <= 1'b0;
        ret_step <= 1'b0;
        repeat (4) @(posedge pclk);
        ret_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        order_exp = order_exp + 64'd4;
        instret_exp = instret_exp + 32'd4;
        pend = 2'd0;
        #1;
        chk("burst order", order_exp, tr_order);
        chk("records seen", order_exp, {32'h0, seen});
        chk("order steps", 64'h0, order_err);
        $display("test burst done");
        // disabled trace: no record, order frozen, instret still counts
        apb(1'b1, `RTP_CTRL_OFS, 32'h0000_0000);
        rec(TK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        apb(1'b1, `RTP_CTRL_OFS, 32'h0000_0003);
        apb(1'b0, `RTP_ORDER_LO_OFS, 32'h0000_0000);
        chk("order lo", order_exp[31:0], rd);
        chk("halt", 64'h1, tr_halt);
        apb(1'b1, `RTP_INSTRET_OFS, 32'h0000_5a5a);
        apb(1'b0, `RTP_INSTRET_OFS, 32'h0000_0000);
        chk("instret", instret_exp, rd);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk("unmapped error", 64'h1, er);
        rec(TK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test registers done");
        give_verdict();
    end
endmodule // tb_top

/* trace_observer.sv */
`timescale 1ns/100ps

// far-side scoreboard: takes the trace port only in cycles with a record
module trace_observer
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watched trace outputs
    input wire logic tr_valid,
    input wire logic [63:0] tr_order,
    // findings for the bench
    output logic [31:0] seen,
    output logic order_err
);
    logic [63:0] last_order; // order of the previous record

    // count records and watch the order step; payload ignored while idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen <= 32'h0000_0000;
            order_err <= 1'b0;
            last_order <= 64'h0000_0000_0000_0000;
        end
        else if (tr_valid)
        begin
            seen <= seen + 32'h0000_0001;
            // a skipped or repeated order means a lost or doubled record
            if (tr_order !== last_order + 64'h0000_0000_0000_0001)
            begin
                order_err <= 1'b1;
            end
            last_order <= tr_order;
        end
    end
endmodule // trace_observer
